// *** hdl/sspx_pkg.sv ***
// Shared constants, encodings and helpers of the shift/subtract/pointer execution unit
package sspx_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SCF = 8'hdf;
  localparam logic [7:0] OP_SRA_R = 8'hd0;
  localparam logic [7:0] OP_SRA_IR = 8'hd1;
  localparam logic [7:0] OP_SRP = 8'h31;
  localparam logic [7:0] OP_STOP = 8'h7f;
  localparam logic [7:0] OP_SUB_RR = 8'h22;
  localparam logic [7:0] OP_SUB_RIR = 8'h23;
  localparam logic [7:0] OP_SUB_GR = 8'h24;
  localparam logic [7:0] OP_SUB_GIR = 8'h25;
  localparam logic [7:0] OP_SUB_IM = 8'h26;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FLG_C = 7;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_S = 5;
  localparam int unsigned FLG_V = 4;
  localparam int unsigned FLG_D = 3;
  localparam int unsigned FLG_H = 2;

  // ----------------------------------------------------------------
  // Pointer-load source selection
  // ----------------------------------------------------------------
  localparam logic [1:0] SRP_SEL_FIRST = 2'h2;
  localparam logic [1:0] SRP_SEL_SECOND = 2'h1;
  localparam logic [1:0] SRP_SEL_BOTH = 2'h0;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'hd4;
  localparam logic [7:0] IDX_FLAGS = 8'hd5;
  localparam logic [7:0] IDX_WPF = 8'hd6;
  localparam logic [7:0] IDX_WPS = 8'hd7;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] WPF_RST = 8'h00;
  localparam logic [7:0] WPS_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AOP_NONE = 2'b00, AOP_SCF = 2'b01, AOP_SRA = 2'b10,
                            AOP_SUB = 2'b11} sspx_aop_t;
  typedef enum logic {EX_IDLE = 1'b0, EX_BUSY = 1'b1} sspx_exec_t;
  typedef enum logic {PWR_RUN = 1'b0, PWR_STOP = 1'b1} sspx_pwr_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic sspx_aop_t op_to_aop(input logic [7:0] op);
    if (op == OP_SCF) return AOP_SCF;
    if (op == OP_SRA_R || op == OP_SRA_IR) return AOP_SRA;
    if (op >= OP_SUB_RR && op <= OP_SUB_IM) return AOP_SUB;
    return AOP_NONE;
  endfunction : op_to_aop

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    if (op >= OP_SUB_RIR && op <= OP_SUB_IM) return CYC_LONG;
    return CYC_SHORT;
  endfunction : op_cycles

endpackage : sspx_pkg

// *** hdl/sspx_alu.sv ***
// Result and flag computation for set-carry, arithmetic shift and subtract
module sspx_alu (
  // Operation and operands
  input wire sspx_pkg::sspx_aop_t aop,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  // Results
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  import sspx_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    sum = {1'b0, dst} + {1'b0, ~src} + 9'h001;
    low = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;
    result = dst;
    flags_out = flags_in;
    unique case (aop)
      AOP_SCF: begin
        flags_out[FLG_C] = 1'b1;
      end
      AOP_SRA: begin
        result = {dst[7], dst[7:1]};
        flags_out[FLG_C] = dst[0];
        flags_out[FLG_Z] = (result == 8'h00);
        flags_out[FLG_S] = result[7];
        flags_out[FLG_V] = 1'b0;
      end
      AOP_SUB: begin
        // Two's complement add; carry out of bit 7 clear means borrow
        result = sum[7:0];
        flags_out[FLG_C] = ~sum[8];
        flags_out[FLG_Z] = (sum[7:0] == 8'h00);
        flags_out[FLG_S] = sum[7];
        flags_out[FLG_V] = (dst[7] != src[7]) && (sum[7] == src[7]);
        flags_out[FLG_D] = 1'b1;
        flags_out[FLG_H] = ~low[4];
      end
      AOP_NONE: begin
        result = dst;
      end
    endcase
  end

endmodule : sspx_alu

// *** hdl/sspx_stop_ctl.sv ***
// Stop-mode state: clock halt outputs and wake on external interrupt
module sspx_stop_ctl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic stop_req,
  input wire logic ext_irq,
  // Status
  output logic halt_q,
  output logic halt_next,
  output logic wake_q
);
  import sspx_pkg::*;

  sspx_pwr_t st_q;
  sspx_pwr_t st_d;
  logic wake_d;

  always_comb begin
    st_d = st_q;
    wake_d = 1'b0;
    unique case (st_q)
      PWR_RUN: begin
        if (stop_req) begin
          st_d = PWR_STOP;
        end
      end
      PWR_STOP: begin
        // Only an external interrupt leaves; reset is the other way out
        if (ext_irq) begin
          st_d = PWR_RUN;
          wake_d = 1'b1;
        end
      end
    endcase
    halt_next = (st_d == PWR_STOP);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= PWR_RUN;
      halt_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      st_q <= st_d;
      halt_q <= halt_next;
      wake_q <= wake_d;
    end
  end

endmodule : sspx_stop_ctl

// *** hdl/sspx_exec.sv ***
// Execution unit top: instruction sequencing, pointers, flags, stop mode, APB registers
// ----------------------------------------------------------------
// What this block does
// - Set-carry forces carry to one, other flags kept, four cycles.
// - Arithmetic right shift moves bits down, bit 7 kept; opcodes D0, D1.
// - Shift: carry gets old bit 0, Z and S from result, V clears.
// - Pointer load 31: select 10 writes first, 01 second, bits 3-7.
// - Select 00 writes bits 4-7 to both; bit 3 zero first, one second.
// - First pointer at location D6, second pointer at location D7.
// - Stop instruction 7F halts CPU and system clocks, no flags changed.
// - Stop mode keeps register contents unchanged, except an APB write set up in the stop commit cycle.
// - Stop mode ends only by external reset or external interrupt.
// - Subtract stores dst minus src via two's complement; opcodes 22 to 26.
// - Subtract: carry on borrow, zero on zero result, sign on negative.
// - Subtract overflow: opposite operand signs and result sign equals source.
// - Subtract sets decimal flag; half-carry set on low-nibble borrow.
// ----------------------------------------------------------------
module sspx_exec #(
  parameter int unsigned PADDR_W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Instruction issue
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_dst,
  input wire logic [7:0] instr_src,
  // Completion and write-back
  output logic instr_done,
  output logic instr_illegal,
  output logic dst_we,
  output logic [7:0] dst_wdata,
  // Architectural state
  output logic [7:0] flags,
  output logic [7:0] window_pointer_first,
  output logic [7:0] window_pointer_second,
  // Stop mode
  input wire logic ext_irq,
  output logic cpu_clk_halt,
  output logic sys_clk_halt,
  output logic stop_wake,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  import sspx_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PADDR_W < 11) begin : g_chk
    $error("PADDR_W must be at least 11");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sspx_exec_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d, dstv_q, dstv_d, srcv_q, srcv_d;
  logic [7:0] flags_q, flags_d, wpf_q, wpf_d, wps_q, wps_d, wdata_q, wdata_d;
  logic ready_q, ready_d, done_q, done_d, ill_q, ill_d, we_q, we_d, stop_req;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic commit, halt_q, halt_next, wake_q, apb_wr;
  logic [7:0] alu_res, alu_flags;
  sspx_aop_t aop;

  function automatic logic map_hit(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && !(|a[PADDR_W-1:10]) && (a[9:2] == idx);
  endfunction : map_hit

  assign aop = op_to_aop(op_q);
  assign commit = (st_q == EX_BUSY) && (cnt_q == 3'h1);

  sspx_alu u_alu (
    .aop(aop),
    .dst(dstv_q),
    .src(srcv_q),
    .flags_in(flags_q),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  sspx_stop_ctl u_stop (
    .mclk(mclk),
    .reset_n(reset_n),
    .stop_req(stop_req),
    .ext_irq(ext_irq),
    .halt_q(halt_q),
    .halt_next(halt_next),
    .wake_q(wake_q)
  );

  // ----------------------------------------------------------------
  // APB slave: data prepared in setup, answered in first access cycle
  // ----------------------------------------------------------------
  assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    pready_d = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (psel && !penable) begin
      if (map_hit(paddr, IDX_WPF)) begin
        prdata_d = {24'h00_0000, wpf_q};
      end else if (map_hit(paddr, IDX_WPS)) begin
        prdata_d = {24'h00_0000, wps_q};
      end else if (map_hit(paddr, IDX_FLAGS)) begin
        prdata_d = {24'h00_0000, flags_q};
      end else if (map_hit(paddr, IDX_STATUS)) begin
        prdata_d = {30'h0000_0000, st_q == EX_BUSY, halt_q};
        pslverr_d = pwrite;
      end else begin
        pslverr_d = 1'b1;
      end
      // Writes set up while halt_q is high are refused; one set up in the stop commit cycle still lands
      if (pwrite && halt_q) begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction sequencing and commit
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    dstv_d = dstv_q;
    srcv_d = srcv_q;
    flags_d = flags_q;
    wpf_d = wpf_q;
    wps_d = wps_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    done_d = 1'b0;
    ill_d = 1'b0;
    stop_req = 1'b0;
    if (apb_wr && map_hit(paddr, IDX_WPF)) wpf_d = pwdata[7:0];
    if (apb_wr && map_hit(paddr, IDX_WPS)) wps_d = pwdata[7:0];
    if (apb_wr && map_hit(paddr, IDX_FLAGS)) flags_d = pwdata[7:0];
    unique case (st_q)
      EX_IDLE: begin
        if (instr_valid && ready_q) begin
          st_d = EX_BUSY;
          cnt_d = op_cycles(instr_opcode) - 3'h1;
          op_d = instr_opcode;
          dstv_d = instr_dst;
          srcv_d = instr_src;
        end
      end
      EX_BUSY: begin
        cnt_d = cnt_q - 3'h1;
        if (commit) begin
          st_d = EX_IDLE;
          done_d = 1'b1;
          unique case (aop)
            AOP_SCF: begin
              flags_d = alu_flags;
            end
            AOP_SRA, AOP_SUB: begin
              // Result and flags land in the same cycle
              we_d = 1'b1;
              wdata_d = alu_res;
              flags_d = alu_flags;
            end
            AOP_NONE: begin
              if (op_q == OP_SRP) begin
                unique case (srcv_q[1:0])
                  SRP_SEL_FIRST: wpf_d[7:3] = srcv_q[7:3];
                  SRP_SEL_SECOND: wps_d[7:3] = srcv_q[7:3];
                  SRP_SEL_BOTH: begin
                    wpf_d[7:3] = {srcv_q[7:4], 1'b0};
                    wps_d[7:3] = {srcv_q[7:4], 1'b1};
                  end
                  default: ill_d = 1'b1;
                endcase
              end else if (op_q == OP_STOP) begin
                stop_req = 1'b1;
              end else begin
                ill_d = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
    // No issue while stopped
    ready_d = (st_d == EX_IDLE) && !halt_next;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= EX_IDLE;
      cnt_q <= 3'h0;
      op_q <= 8'h00;
      dstv_q <= 8'h00;
      srcv_q <= 8'h00;
      flags_q <= FLAGS_RST;
      wpf_q <= WPF_RST;
      wps_q <= WPS_RST;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      dstv_q <= dstv_d;
      srcv_q <= srcv_d;
      flags_q <= flags_d;
      wpf_q <= wpf_d;
      wps_q <= wps_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      done_q <= done_d;
      ill_q <= ill_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign instr_ready = ready_q;
  assign instr_done = done_q;
  assign instr_illegal = ill_q;
  assign dst_we = we_q;
  assign dst_wdata = wdata_q;
  assign flags = flags_q;
  assign window_pointer_first = wpf_q;
  assign window_pointer_second = wps_q;
  assign cpu_clk_halt = halt_q;
  assign sys_clk_halt = halt_q;
  assign stop_wake = wake_q;
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_scf_carry: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && op_q == OP_SCF |=> flags_q[FLG_C] && flags_q[6:0] == $past(flags_q[6:0]))
    else $error("set-carry flag result wrong");
  a_sra_value: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && aop == AOP_SRA |=> dst_we && dst_wdata == {$past(dstv_q[7]), $past(dstv_q[7:1])})
    else $error("shift result wrong");
  a_sra_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && aop == AOP_SRA |=> flags_q[FLG_C] == $past(dstv_q[0]) && !flags_q[FLG_V]
      && flags_q[FLG_D] == $past(flags_q[FLG_D]) && flags_q[FLG_H] == $past(flags_q[FLG_H]))
    else $error("shift flags wrong");
  a_srp_first: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && op_q == OP_SRP && srcv_q[1:0] == SRP_SEL_FIRST
      |=> wpf_q[7:3] == $past(srcv_q[7:3]) && $stable(wps_q))
    else $error("first pointer load wrong");
  a_srp_both: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && op_q == OP_SRP && srcv_q[1:0] == SRP_SEL_BOTH |=>
      wpf_q[7:3] == {$past(srcv_q[7:4]), 1'b0} && wps_q[7:3] == {$past(srcv_q[7:4]), 1'b1})
    else $error("both pointer load wrong");
  a_ptr_read: assert property (@(posedge mclk) disable iff (!reset_n)
    psel && !penable && !pwrite && map_hit(paddr, IDX_WPS) |=> prdata[7:0] == $past(wps_q))
    else $error("second pointer readback wrong");
  a_stop_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && op_q == OP_STOP |=> cpu_clk_halt && sys_clk_halt && $stable(flags_q))
    else $error("stop not entered");
  a_stop_retain: assert property (@(posedge mclk) disable iff (!reset_n)
    halt_q && !ext_irq |=> $stable(wpf_q) && $stable(wps_q) && $stable(flags_q) && !instr_ready)
    else $error("state changed in stop mode");
  a_stop_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    halt_q && !ext_irq |=> halt_q)
    else $error("stop left without interrupt");
  a_sub_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && aop == AOP_SUB |=> dst_wdata == ($past(dstv_q) - $past(srcv_q))
      && flags_q[FLG_C] == ($past(srcv_q) > $past(dstv_q))
      && flags_q[FLG_Z] == (dst_wdata == 8'h00) && flags_q[FLG_S] == dst_wdata[7])
    else $error("subtract result or flags wrong");
  a_sub_ovf: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && aop == AOP_SUB |=> flags_q[FLG_V] ==
      ($past(dstv_q[7]) != $past(srcv_q[7]) && dst_wdata[7] == $past(srcv_q[7])))
    else $error("subtract overflow wrong");
  a_sub_half: assert property (@(posedge mclk) disable iff (!reset_n)
    commit && aop == AOP_SUB |=> flags_q[FLG_D]
      && flags_q[FLG_H] == ($past(srcv_q[3:0]) > $past(dstv_q[3:0])))
    else $error("subtract decimal or half flag wrong");
  a_long_cycles: assert property (@(posedge mclk) disable iff (!reset_n)
    instr_valid && instr_ready && op_cycles(instr_opcode) == CYC_LONG
      |=> !instr_done [*5] ##1 instr_done)
    else $error("six-cycle timing wrong");
  a_short_cycles: assert property (@(posedge mclk) disable iff (!reset_n)
    instr_valid && instr_ready && op_cycles(instr_opcode) == CYC_SHORT
      |=> !instr_done [*3] ##1 instr_done)
    else $error("four-cycle timing wrong");

endmodule : sspx_exec

// *** verification/sspx_istream.sv ***
// Instruction stream model feeding the execution unit
module sspx_istream #(
  // Stand-in code for a no-operation, arbitrary
  parameter logic [7:0] NOP_OP = 8'hff
) (
  // Clock
  input wire logic mclk,
  // Issue handshake
  input wire logic instr_ready,
  input wire logic instr_done,
  output logic instr_valid,
  output logic [7:0] instr_opcode,
  output logic [7:0] instr_dst,
  output logic [7:0] instr_src
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_dst = 8'h00;
    instr_src = 8'h00;
  end

  // ------
  // Offer, hold until taken, count edges to done
  // ------
  task automatic issue(input logic [7:0] op, d, s, output int n);
    n = 0;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    instr_dst <= d;
    instr_src <= s;
    do begin
      @(posedge mclk);
    end while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    // Released operands show no stale value
    instr_opcode <= ~op;
    instr_dst <= ~d;
    instr_src <= ~s;
    do begin
      @(posedge mclk);
      n++;
    end while (instr_done !== 1'b1);
  endtask : issue

  // Padding after a stop
  task automatic no_ops();
    int n;
    repeat (3) issue(NOP_OP, 8'h00, 8'h00, n);
  endtask : no_ops
endmodule : sspx_istream

// *** verification/tb_top.sv ***
// Testbench for the shift/subtract/pointer execution unit
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sspx_pkg::*;

  logic mclk = 1'b0;
  logic reset_n, ext_irq, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, instr_valid, instr_ready, instr_done, instr_illegal, dst_we;
  logic cpu_clk_halt, sys_clk_halt, stop_wake;
  logic [7:0] instr_opcode, instr_dst, instr_src, dst_wdata, flags, wpf, wps;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  always #12.5 mclk = ~mclk;

  sspx_exec #(.PADDR_W(12)) DUT (.mclk(mclk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_opcode(instr_opcode),
    .instr_dst(instr_dst), .instr_src(instr_src), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .dst_we(dst_we), .dst_wdata(dst_wdata), .flags(flags),
    .window_pointer_first(wpf), .window_pointer_second(wps), .ext_irq(ext_irq),
    .cpu_clk_halt(cpu_clk_halt), .sys_clk_halt(sys_clk_halt), .stop_wake(stop_wake),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  sspx_istream ist (.mclk(mclk), .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode), .instr_dst(instr_dst),
    .instr_src(instr_src));

  // ------
  // Helpers
  // ------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] sub_exp(input logic [7:0] d, s, f);
    logic [7:0] r, g;
    r = d - s;
    g = f;
    g[FLG_C] = s > d;
    g[FLG_Z] = r == 8'h00;
    g[FLG_S] = r[7];
    g[FLG_V] = (d[7] != s[7]) && (r[7] == s[7]);
    g[FLG_D] = 1'b1;
    g[FLG_H] = s[3:0] > d[3:0];
    return {r, g};
  endfunction : sub_exp

  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    apb(1'b0, ad(IDX_WPS), 32'h0);
    chk(rd, 32'h0, "second pointer reset");
    apb(1'b0, 12'h360, 32'h0);
    chk(er, 1'b1, "unmapped read refused");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, ad(IDX_STATUS), 32'h3);
    chk(er, 1'b1, "status write refused");
  endtask : t_regs

  task automatic t_scf();
    apb(1'b1, ad(IDX_FLAGS), 32'h7f);
    ist.issue(OP_SCF, 8'h00, 8'h00, n);
    chk(n, 4, "set-carry cycles");
    chk(flags, 8'hff, "set-carry flags");
    chk({dst_we, instr_illegal}, 2'b00, "set-carry no write");
  endtask : t_scf

  task automatic t_sra();
    apb(1'b1, ad(IDX_FLAGS), 32'h9e);
    ist.issue(OP_SRA_R, 8'h9a, 8'h00, n);
    chk(dst_wdata, 8'hcd, "shift result");
    chk(dst_we, 1'b1, "shift writes destination");
    chk(flags, 8'h2e, "shift flags");
    ist.issue(OP_SRA_IR, 8'h01, 8'h00, n);
    chk(dst_wdata, 8'h00, "shift to zero");
    chk(flags, 8'hce, "shift zero flags");
  endtask : t_sra

  task automatic t_srp();
    apb(1'b1, ad(IDX_WPF), 32'h07);
    ist.issue(OP_SRP, 8'h00, 8'h40, n);
    chk({wpf, wps}, 16'h4748, "both pointers");
    chk(flags, 8'hce, "pointer load keeps flags");
    ist.issue(OP_SRP, 8'h00, 8'h52, n);
    chk({wpf, wps}, 16'h5748, "first pointer");
    ist.issue(OP_SRP, 8'h00, 8'h69, n);
    chk({wpf, wps}, 16'h5768, "second pointer");
    ist.issue(OP_SRP, 8'h00, 8'hfb, n);
    chk({instr_illegal, wpf, wps}, {1'b1, 16'h5768}, "pointer select 11 refused");
    apb(1'b0, ad(IDX_WPF), 32'h0);
    chk(rd, 32'h57, "first pointer location");
    apb(1'b0, ad(IDX_WPS), 32'h0);
    chk(rd, 32'h68, "second pointer location");
  endtask : t_srp

  task automatic t_sub();
    logic [7:0] op[7] = '{OP_SUB_RR, OP_SUB_RIR, OP_SUB_GR, OP_SUB_GIR, OP_SUB_IM,
                          OP_SUB_IM, OP_SUB_RR};
    logic [7:0] dv[7] = '{8'h12, 8'h12, 8'h21, 8'h21, 8'h21, 8'h21, 8'h03};
    logic [7:0] sv[7] = '{8'h03, 8'h0a, 8'h03, 8'h0a, 8'h90, 8'h65, 8'h03};
    logic [15:0] e;
    logic [7:0] fm;
    fm = 8'h01;
    apb(1'b1, ad(IDX_FLAGS), {24'h0, fm});
    for (int i = 0; i < 7; i++) begin
      e = sub_exp(dv[i], sv[i], fm);
      fm = e[7:0];
      ist.issue(op[i], dv[i], sv[i], n);
      chk(n, (op[i] == OP_SUB_RR) ? 4 : 6, "subtract cycles");
      chk(dst_wdata, e[15:8], "subtract result");
      chk(flags[7:4], fm[7:4], "subtract C Z S V");
      chk(flags[3:0], fm[3:0], "subtract D H");
    end
  endtask : t_sub

  task automatic t_stop();
    apb(1'b1, ad(IDX_FLAGS), 32'h5a);
    ist.issue(OP_STOP, 8'h00, 8'h00, n);
    chk(n, 4, "stop cycles");
    chk({cpu_clk_halt, sys_clk_halt, instr_ready}, 3'b110, "halted");
    apb(1'b1, ad(IDX_WPF), 32'hff);
    chk(er, 1'b1, "write while halted");
    apb(1'b0, ad(IDX_FLAGS), 32'h0);
    chk(rd, 32'h5a, "flags kept");
    apb(1'b0, ad(IDX_WPF), 32'h0);
    chk(rd, 32'h57, "pointer kept");
    chk(cpu_clk_halt, 1'b1, "still halted");
    @(posedge mclk);
    ext_irq <= 1'b1;
    @(posedge mclk);
    ext_irq <= 1'b0;
    @(posedge mclk);
    chk({cpu_clk_halt, stop_wake, instr_ready}, 3'b011, "irq wake");
    ist.no_ops();
    chk(flags, 8'h5a, "flags after padding");
    ist.issue(OP_STOP, 8'h00, 8'h00, n);
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk(cpu_clk_halt, 1'b0, "reset wake");
  endtask : t_stop

  initial begin
    reset_n = 1'b0;
    ext_irq = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_regs();
    t_scf();
    t_sra();
    t_srp();
    t_sub();
    t_stop();
    finish_test();
  end
endmodule : tb_top
